// [core/sfpc_top.sv]
// Operation
// RULE1: Rate field picks frame rate, 166.67Hz to 64kHz
// RULE2: Style bit: 50% clock or synced frame pulse
// RULE3: Edge bit: pulse on rising or falling edge
// RULE4: Width field: fixed E1 widths or one synth cycle
// RULE5: Software uses fixed widths only for E1 multiples
// RULE6: Polarity bit: 0 active high, 1 active low
// RULE7: Offset bits 15:0 held at two byte registers
// RULE8: Low offset delays pulse in 262.144MHz steps
// RULE9: Upper offset bits shift in 8kHz cycles
// RULE10: Run bit low holds the output low
// RULE11: All pulse timing locked to synth clock edges
//
// The plain strobed port was decided locally.
`include "sfpc_map.svh"

module sfpc_top (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic synth_clock_out_a,
	output logic frame_pulse_out_a
);

	localparam logic [3:0] W4M_CYC = 4'(`SFPC_CYC(`SFPC_W4M_PS));
	localparam logic [3:0] W8M_CYC = 4'(`SFPC_CYC(`SFPC_W8M_PS));
	localparam logic [3:0] W16M_CYC = 4'(`SFPC_CYC(`SFPC_W16M_PS));
	localparam logic [3:0] W32M_CYC = 4'(`SFPC_CYC(`SFPC_W32M_PS));
	localparam logic [3:0] W65M_CYC = 4'(`SFPC_CYC(`SFPC_W65M_PS));
	localparam logic [17:0] BASE_CYC = 18'(`SFPC_BASE_CYCLES);

	// Register fields
	logic [2:0] rate_q;
	logic style_q;
	logic edge_q;
	logic [2:0] width_code_q;
	logic pol_q;
	logic [15:0] fine_q;
	logic [5:0] coarse_q;
	logic run_q;
	logic [7:0] stat;

	// Timing
	logic align_tick;
	logic synth_prev_q;
	logic synth_rise;
	logic synth_fall;
	logic sync_edge;
	sfpc_pkg::sfpc_state_t state_q;
	sfpc_pkg::sfpc_state_t state_d;
	logic [13:0] delay_q;
	logic [13:0] fine_cyc;
	logic [3:0] width_cnt_q;
	logic [16:0] since_q;
	logic [16:0] half_cyc;
	logic width_follows_synth;
	logic active;

	// Fine offset steps to reference cycles, rounded down
	function automatic logic [13:0] fine_to_cycles(input logic [15:0] steps);
		logic [33:0] prod;
		prod = 34'(steps) * 34'(`SFPC_REF_KHZ);
		return 14'(prod / 34'(`SFPC_FINE_KHZ));
	endfunction

	// Predefined E1 widths in reference cycles
	function automatic logic [3:0] width_cycles(input logic [2:0] code);
		logic [3:0] w;
		w = W65M_CYC;
		unique case (code)
			3'h0: w = W4M_CYC;
			3'h1: w = W8M_CYC;
			3'h2: w = W16M_CYC;
			3'h3: w = W32M_CYC;
			3'h4: w = W65M_CYC;
			3'h5, 3'h6, 3'h7: w = W65M_CYC;
		endcase
		return w;
	endfunction

	sfpc_regs u_regs (
		.ref_clk(ref_clk),
		.rst(rst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.stat_in(stat),
		.rate_q(rate_q),
		.style_q(style_q),
		.edge_q(edge_q),
		.width_q(width_code_q),
		.pol_q(pol_q),
		.fine_q(fine_q),
		.coarse_q(coarse_q),
		.run_q(run_q)
	);

	sfpc_rate_gen u_rate (
		.ref_clk(ref_clk),
		.rst(rst),
		.rate(rate_q),
		.coarse(coarse_q),
		.align_tick(align_tick)
	);

	// Synth clock is synchronous to ref_clk; keep last sample for edge detection
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			synth_prev_q <= 1'b0;
		end else begin
			synth_prev_q <= synth_clock_out_a;
		end
	end

	// Edge choice and derived counts
	always_comb begin
		synth_rise = synth_clock_out_a && !synth_prev_q;
		synth_fall = !synth_clock_out_a && synth_prev_q;
		sync_edge = edge_q ? synth_fall : synth_rise; // RULE3
		fine_cyc = fine_to_cycles(fine_q); // RULE8
		half_cyc = 17'((18'(sfpc_pkg::sfpc_rate_mult(rate_q)) * BASE_CYC) >> 1); // RULE2
		// Reserved codes 101/110 fall back to one synth cycle, the only safe width
		width_follows_synth = width_code_q == `SFPC_WIDTH_SYNTH || width_code_q == 3'h5 || width_code_q == 3'h6;
		active = state_q == sfpc_pkg::SFPC_ST_ACTIVE;
		stat = {5'h00, state_q != sfpc_pkg::SFPC_ST_IDLE && !active, active, frame_pulse_out_a};
	end

	// Sequencer: frame tick, fine delay, wait for synth edge, then drive
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			sfpc_pkg::SFPC_ST_IDLE: begin
				if (align_tick) begin
					state_d = (fine_cyc == 14'h0000) ? sfpc_pkg::SFPC_ST_ARM : sfpc_pkg::SFPC_ST_DELAY; // RULE8
				end
			end
			sfpc_pkg::SFPC_ST_DELAY: begin
				if (delay_q == 14'h0001) begin
					state_d = sfpc_pkg::SFPC_ST_ARM; // RULE8
				end
			end
			sfpc_pkg::SFPC_ST_ARM: begin
				if (sync_edge) begin
					state_d = sfpc_pkg::SFPC_ST_ACTIVE; // RULE11
				end
			end
			sfpc_pkg::SFPC_ST_ACTIVE: begin
				if (style_q == `SFPC_STYLE_BIT) begin
					if (since_q >= half_cyc - 17'h00001) begin
						state_d = sfpc_pkg::SFPC_ST_IDLE; // RULE2
					end
				end else if (width_follows_synth) begin
					if (sync_edge) begin
						state_d = sfpc_pkg::SFPC_ST_IDLE; // RULE4
					end
				end else if (width_cnt_q <= 4'h1) begin
					state_d = sfpc_pkg::SFPC_ST_IDLE; // RULE4
				end
			end
			default: state_d = sfpc_pkg::SFPC_ST_IDLE;
		endcase
		if (!run_q) begin
			state_d = sfpc_pkg::SFPC_ST_IDLE; // RULE10
		end
	end

	// State register
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= sfpc_pkg::SFPC_ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Fine delay countdown; a delay longer than the frame swallows the next tick
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			delay_q <= 14'h0000;
		end else if (state_q == sfpc_pkg::SFPC_ST_IDLE) begin
			delay_q <= fine_cyc; // RULE8
		end else if (state_q == sfpc_pkg::SFPC_ST_DELAY) begin
			delay_q <= delay_q - 14'h0001;
		end
	end

	// Width and half-period counters, restarted on each synth-edge launch
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			width_cnt_q <= 4'h0;
			since_q <= 17'h00000;
		end else if (state_q == sfpc_pkg::SFPC_ST_ARM) begin
			width_cnt_q <= width_cycles(width_code_q); // RULE4
			since_q <= 17'h00000;
		end else if (active) begin
			width_cnt_q <= width_cnt_q - 4'h1;
			since_q <= since_q + 17'h00001; // RULE2
		end
	end

	// Output flop: polarity applied before the run gate, so run low forces low whatever the polarity
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			frame_pulse_out_a <= 1'b0;
		end else begin
			frame_pulse_out_a <= run_q && (active ^ pol_q); // RULE6 RULE10
		end
	end

	// Helper: cycles between frame ticks with stable rate and offset
	logic [17:0] gap_q;
	logic gap_valid_q;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			gap_q <= 18'h00000;
			gap_valid_q <= 1'b0;
		end else if (align_tick) begin
			gap_q <= 18'h00000;
			gap_valid_q <= !reg_wr; // A write landing on the tick itself makes the next period irregular
		end else begin
			gap_q <= gap_q + 18'h00001;
			if (reg_wr) begin
				gap_valid_q <= 1'b0;
			end
		end
	end

	property p_frame_period;
		@(posedge ref_clk) disable iff (rst)
		align_tick && gap_valid_q && !reg_wr |->
			gap_q == 18'(18'(sfpc_pkg::sfpc_rate_mult(rate_q)) * BASE_CYC - 18'h00001);
	endproperty
	a_frame_period: assert property (p_frame_period) else $error("frame period wrong for rate"); // RULE1

	property p_clock_half;
		@(posedge ref_clk) disable iff (rst)
		active && run_q && style_q == `SFPC_STYLE_BIT && since_q == half_cyc - 17'h00001 |=> !active;
	endproperty
	a_clock_half: assert property (p_clock_half) else $error("clock style not 50 percent"); // RULE2

	property p_rise_launch;
		@(posedge ref_clk) disable iff (rst)
		state_q == sfpc_pkg::SFPC_ST_ARM && run_q && !edge_q && synth_rise |=> active;
	endproperty
	a_rise_launch: assert property (p_rise_launch) else $error("no launch on rising synth edge"); // RULE3

	property p_hold_without_edge;
		@(posedge ref_clk) disable iff (rst)
		state_q == sfpc_pkg::SFPC_ST_ARM && run_q && !sync_edge |=> state_q == sfpc_pkg::SFPC_ST_ARM;
	endproperty
	a_hold_without_edge: assert property (p_hold_without_edge) else $error("launch without synth edge"); // RULE11

	property p_width_8m;
		@(posedge ref_clk) disable iff (rst)
		(!$past(reg_wr) && $rose(active) && style_q && width_code_q == 3'h1 && run_q && !reg_wr)
			##1 (run_q && !reg_wr)[*2] |-> ($past(active) && active) ##1 active ##1 !active;
	endproperty
	a_width_8m: assert property (p_width_8m) else $error("8.192 MHz width not four cycles"); // RULE4

	property p_polarity_idle;
		@(posedge ref_clk) disable iff (rst)
		run_q && state_q == sfpc_pkg::SFPC_ST_IDLE |=> frame_pulse_out_a == $past(pol_q);
	endproperty
	a_polarity_idle: assert property (p_polarity_idle) else $error("idle level ignores polarity"); // RULE6

	property p_delay_end;
		@(posedge ref_clk) disable iff (rst)
		state_q == sfpc_pkg::SFPC_ST_DELAY && delay_q == 14'h0001 && run_q |=> state_q == sfpc_pkg::SFPC_ST_ARM;
	endproperty
	a_delay_end: assert property (p_delay_end) else $error("fine delay did not end on count"); // RULE8

	property p_delay_step;
		@(posedge ref_clk) disable iff (rst)
		state_q == sfpc_pkg::SFPC_ST_DELAY && delay_q > 14'h0001 && run_q |=>
			state_q == sfpc_pkg::SFPC_ST_DELAY && delay_q == $past(delay_q) - 14'h0001;
	endproperty
	a_delay_step: assert property (p_delay_step) else $error("fine delay not counting down"); // RULE8

	property p_run_low;
		@(posedge ref_clk) disable iff (rst)
		!run_q |=> !frame_pulse_out_a && state_q == sfpc_pkg::SFPC_ST_IDLE;
	endproperty
	a_run_low: assert property (p_run_low) else $error("output not held low when stopped"); // RULE10

endmodule

// [core/sfpc_map.svh]
`ifndef SFPC_MAP_SVH
`define SFPC_MAP_SVH

// Register offsets
`define SFPC_OFF_CTRL 8'h30
`define SFPC_OFF_STAT 8'h31
`define SFPC_OFF_RATE 8'h3e
`define SFPC_OFF_SHAPE 8'h3f
`define SFPC_OFF_PHASE_LOW 8'h40
`define SFPC_OFF_PHASE_MID 8'h41
`define SFPC_OFF_PHASE_HIGH 8'h42

// Reset values
`define SFPC_RST_CTRL 8'h01
`define SFPC_RST_RATE 8'h05
`define SFPC_RST_SHAPE 8'h83
`define SFPC_RST_PHASE 8'h00

// Field positions
`define SFPC_RUN_BIT 0
`define SFPC_RATE_LSB 0
`define SFPC_STYLE_BIT 1'b0
`define SFPC_STYLE_POS 0
`define SFPC_EDGE_POS 1
`define SFPC_WIDTH_LSB 4
`define SFPC_POL_POS 7
`define SFPC_HIGH_MSB 5
`define SFPC_STAT_OUT_POS 0
`define SFPC_STAT_ACTIVE_POS 1
`define SFPC_STAT_WAIT_POS 2

// Width code that follows the synthesizer clock
`define SFPC_WIDTH_SYNTH 3'h7

// Timing: reference clock and 64 kHz base period
`define SFPC_REF_PERIOD_PS 25000
`define SFPC_REF_KHZ 40000
`define SFPC_BASE_PERIOD_PS 15625000
`define SFPC_BASE_CYCLES (`SFPC_BASE_PERIOD_PS / `SFPC_REF_PERIOD_PS)
`define SFPC_COARSE_PERIOD_PS 125000000
`define SFPC_COARSE_BASES (`SFPC_COARSE_PERIOD_PS / `SFPC_BASE_PERIOD_PS)
`define SFPC_FINE_KHZ 262144

// Frame periods in 64 kHz base periods, per rate code
`define SFPC_MULT_166HZ 384
`define SFPC_MULT_400HZ 160
`define SFPC_MULT_1KHZ 64
`define SFPC_MULT_2KHZ 32
`define SFPC_MULT_4KHZ 16
`define SFPC_MULT_8KHZ 8
`define SFPC_MULT_32KHZ 2
`define SFPC_MULT_64KHZ 1

// Pulse widths: times, and cycles rounded down to at least one
`define SFPC_W4M_PS 244141
`define SFPC_W8M_PS 122070
`define SFPC_W16M_PS 61035
`define SFPC_W32M_PS 30518
`define SFPC_W65M_PS 15259
`define SFPC_CYC(ps) (((ps) / `SFPC_REF_PERIOD_PS) < 1 ? 1 : ((ps) / `SFPC_REF_PERIOD_PS))

`endif

// [core/sfpc_pkg.sv]
`include "sfpc_map.svh"

package sfpc_pkg;

	// Sequencer states, one-hot
	typedef enum logic [3:0] {
		SFPC_ST_IDLE = 4'b0001,
		SFPC_ST_DELAY = 4'b0010,
		SFPC_ST_ARM = 4'b0100,
		SFPC_ST_ACTIVE = 4'b1000
	} sfpc_state_t;

	typedef logic [2:0] sfpc_rate_t;
	typedef logic [8:0] sfpc_mult_t;

	// Frame period in 64 kHz base periods
	function automatic sfpc_mult_t sfpc_rate_mult(input sfpc_rate_t rate);
		sfpc_mult_t m;
		m = 9'(`SFPC_MULT_64KHZ);
		unique case (rate)
			3'h0: m = 9'(`SFPC_MULT_166HZ);
			3'h1: m = 9'(`SFPC_MULT_400HZ);
			3'h2: m = 9'(`SFPC_MULT_1KHZ);
			3'h3: m = 9'(`SFPC_MULT_2KHZ);
			3'h4: m = 9'(`SFPC_MULT_4KHZ);
			3'h5: m = 9'(`SFPC_MULT_8KHZ);
			3'h6: m = 9'(`SFPC_MULT_32KHZ);
			3'h7: m = 9'(`SFPC_MULT_64KHZ);
		endcase
		return m;
	endfunction

endpackage

// [core/sfpc_regs.sv]
`include "sfpc_map.svh"

module sfpc_regs (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] stat_in,
	output logic [2:0] rate_q,
	output logic style_q,
	output logic edge_q,
	output logic [2:0] width_q,
	output logic pol_q,
	output logic [15:0] fine_q,
	output logic [5:0] coarse_q,
	output logic run_q
);

	localparam logic [7:0] RATE_RST = `SFPC_RST_RATE;
	localparam logic [7:0] SHAPE_RST = `SFPC_RST_SHAPE;
	localparam logic [7:0] PHASE_RST = `SFPC_RST_PHASE;
	localparam logic [7:0] CTRL_RST = `SFPC_RST_CTRL;

	// Frame rate field
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rate_q <= RATE_RST[2:0];
		end else if (reg_wr && reg_addr == `SFPC_OFF_RATE) begin
			rate_q <= reg_wdata[`SFPC_RATE_LSB +: 3]; // RULE1
		end
	end

	// Shape fields: style, edge, width, polarity
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			style_q <= SHAPE_RST[`SFPC_STYLE_POS];
			edge_q <= SHAPE_RST[`SFPC_EDGE_POS];
			width_q <= SHAPE_RST[`SFPC_WIDTH_LSB +: 3];
			pol_q <= SHAPE_RST[`SFPC_POL_POS];
		end else if (reg_wr && reg_addr == `SFPC_OFF_SHAPE) begin
			style_q <= reg_wdata[`SFPC_STYLE_POS]; // RULE2
			edge_q <= reg_wdata[`SFPC_EDGE_POS]; // RULE3
			width_q <= reg_wdata[`SFPC_WIDTH_LSB +: 3]; // RULE4
			pol_q <= reg_wdata[`SFPC_POL_POS]; // RULE6
		end
	end

	// Phase offset bytes and run enable
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			fine_q <= {PHASE_RST, PHASE_RST};
			coarse_q <= PHASE_RST[`SFPC_HIGH_MSB:0];
			run_q <= CTRL_RST[`SFPC_RUN_BIT];
		end else if (reg_wr) begin
			if (reg_addr == `SFPC_OFF_PHASE_LOW) begin
				fine_q[7:0] <= reg_wdata; // RULE7
			end
			if (reg_addr == `SFPC_OFF_PHASE_MID) begin
				fine_q[15:8] <= reg_wdata; // RULE7
			end
			if (reg_addr == `SFPC_OFF_PHASE_HIGH) begin
				coarse_q <= reg_wdata[`SFPC_HIGH_MSB:0]; // RULE9
			end
			if (reg_addr == `SFPC_OFF_CTRL) begin
				run_q <= reg_wdata[`SFPC_RUN_BIT]; // RULE10
			end
		end
	end

	// Read data valid only in the cycle after the strobe; reserved bits and holes read zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`SFPC_OFF_RATE: reg_rdata <= {5'h00, rate_q};
				`SFPC_OFF_SHAPE: reg_rdata <= {pol_q, width_q, 2'h0, edge_q, style_q};
				`SFPC_OFF_PHASE_LOW: reg_rdata <= fine_q[7:0];
				`SFPC_OFF_PHASE_MID: reg_rdata <= fine_q[15:8];
				`SFPC_OFF_PHASE_HIGH: reg_rdata <= {2'h0, coarse_q};
				`SFPC_OFF_CTRL: reg_rdata <= {7'h00, run_q};
				`SFPC_OFF_STAT: reg_rdata <= stat_in;
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	property p_low_write;
		@(posedge ref_clk) disable iff (rst)
		reg_wr && reg_addr == `SFPC_OFF_PHASE_LOW |=> fine_q[7:0] == $past(reg_wdata);
	endproperty
	a_low_write: assert property (p_low_write) else $error("low offset byte not stored"); // RULE7

	property p_mid_read;
		@(posedge ref_clk) disable iff (rst)
		reg_rd && reg_addr == `SFPC_OFF_PHASE_MID && !reg_wr |=> reg_rdata == fine_q[15:8];
	endproperty
	a_mid_read: assert property (p_mid_read) else $error("mid offset byte read back wrong"); // RULE7

endmodule

// [core/sfpc_rate_gen.sv]
`include "sfpc_map.svh"

module sfpc_rate_gen (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [2:0] rate,
	input wire logic [5:0] coarse,
	output logic align_tick
);

	localparam logic [9:0] BASE_LAST = 10'(`SFPC_BASE_CYCLES - 1);

	logic [9:0] base_cnt_q;
	logic [8:0] frame_idx_q;
	logic [8:0] mult;
	logic [8:0] target;

	// Coarse offset in 8 kHz steps, folded into the current frame
	always_comb begin
		mult = sfpc_pkg::sfpc_rate_mult(rate);
		target = 9'((12'(coarse) * 12'(`SFPC_COARSE_BASES)) % 12'(mult)); // RULE9
	end

	// 64 kHz base counter and frame index; a rate change that shrinks the frame wraps at once
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			base_cnt_q <= 10'h000;
			frame_idx_q <= 9'h000;
		end else if (base_cnt_q == BASE_LAST) begin
			base_cnt_q <= 10'h000;
			frame_idx_q <= (frame_idx_q >= mult - 9'h001) ? 9'h000 : frame_idx_q + 9'h001; // RULE1
		end else begin
			base_cnt_q <= base_cnt_q + 10'h001;
			if (frame_idx_q >= mult) begin
				frame_idx_q <= 9'h000;
			end
		end
	end

	// One tick per frame at the coarse phase point
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			align_tick <= 1'b0;
		end else begin
			align_tick <= (base_cnt_q == 10'h000) && (frame_idx_q == target); // RULE1
		end
	end

	property p_tick_on_base;
		@(posedge ref_clk) disable iff (rst)
		align_tick |-> $past(base_cnt_q) == 10'h000;
	endproperty
	a_tick_on_base: assert property (p_tick_on_base) else $error("frame tick off the base grid"); // RULE9

endmodule

// [verification/sfpc_framer_model.sv]
// Downstream framer: supplies the synth clock and times the frame pulse
module sfpc_framer_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic synth_e1,
	input wire logic pol,
	input wire logic frame_pulse_out_a,
	output logic synth_clock_out_a,
	output int start_cyc,
	output int width,
	output int count
);
	timeunit 1ns;
	timeprecision 1ps;
	logic e1_clk;
	logic act;
	logic act_q;
	int div;
	int cyc;
	int run_len;

	// E1-family stand-in with a 125 ns period: a whole number of periods per 64 kHz frame, so launches
	// repeat exactly; the 5 ns offset keeps its edges clear of both ref_clk edges
	initial begin
		e1_clk = 1'b0;
		#5;
		forever #62.5 e1_clk = ~e1_clk;
	end

	// Non-E1 clock at ref_clk/5, so its phase repeats every 625-cycle frame
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div <= 0;
		end else begin
			div <= (div == 4) ? 0 : div + 1;
		end
	end

	assign synth_clock_out_a = synth_e1 ? e1_clk : (div < 2);
	// Active level follows the programmed polarity
	assign act = frame_pulse_out_a ^ pol;

	// Start time, pulse count and width of the last finished pulse
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cyc <= 0;
			act_q <= 1'b0;
			run_len <= 0;
			start_cyc <= 0;
			width <= 0;
			count <= 0;
		end else begin
			cyc <= cyc + 1;
			act_q <= act;
			if (act && !act_q) begin
				start_cyc <= cyc;
				count <= count + 1;
				run_len <= 1;
			end else if (act) begin
				run_len <= run_len + 1;
			end
			if (!act && act_q) begin
				width <= run_len;
			end
		end
	end
endmodule

// [verification/synth_frame_pulse_config_bench.sv]
`include "sfpc_map.svh"

`define SFPC_CHECK(g, e) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); \
	end \
end

module synth_frame_pulse_config_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] exp;
	} sfpc_row_t;
	logic ref_clk;
	logic rst;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic synth_clock_out_a;
	logic frame_pulse_out_a;
	logic synth_e1;
	logic pol_sel;
	logic any_high;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	int act_start;
	int act_width;
	int act_count;
	int s0;
	int sh;
	// Frame length in 64 kHz periods per rate code, and widths in 25 ns cycles
	int rate_mult[8] = '{384, 160, 64, 32, 16, 8, 2, 1};
	int width_exp[5] = '{9, 4, 2, 1, 1};
	// Reserved bits read back as zero; unmapped address reads zero
	sfpc_row_t rows[9] = '{'{8'h3e, 8'hff, 8'h07}, '{8'h3e, 8'h00, 8'h00}, '{8'h3f, 8'hff, 8'hf3},
		'{8'h3f, 8'h00, 8'h00}, '{8'h40, 8'ha5, 8'ha5}, '{8'h41, 8'h5a, 8'h5a}, '{8'h42, 8'hff, 8'h3f},
		'{8'h30, 8'hfe, 8'h00}, '{8'h50, 8'hff, 8'h00}};

	sfpc_top i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.synth_clock_out_a(synth_clock_out_a), .frame_pulse_out_a(frame_pulse_out_a));

	sfpc_framer_model i_model (.ref_clk(ref_clk), .rst(rst), .synth_e1(synth_e1), .pol(pol_sel),
		.frame_pulse_out_a(frame_pulse_out_a), .synth_clock_out_a(synth_clock_out_a),
		.start_cyc(act_start), .width(act_width), .count(act_count));

	// 40 MHz reference clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// Hang guard, well above the roughly 67k cycles the run needs
	initial begin
		forever begin
			@(posedge ref_clk);
			cycles++;
			if (cycles == 120000) begin
				mismatches++;
				print_verdict();
			end
		end
	end

	task automatic print_verdict();
		if (mismatches == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// One-cycle write; a gap follows so the strobe is never set twice at one edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		`SFPC_CHECK(reg_rdata, exp)
		@(posedge ref_clk);
		#1;
		`SFPC_CHECK(reg_rdata, 8'h00)
	endtask

	task automatic wait_pulses(input int n);
		int c0;
		c0 = act_count;
		for (int i = 0; i < 30000 && act_count < c0 + n; i++) begin
			@(posedge ref_clk);
		end
		#1;
	endtask

	initial begin
		rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		synth_e1 = 1'b1;
		pol_sel = 1'b1;
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		// Register table: write, then read back
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr, rows[i].exp);
		end
		// Second reset in mid-run restores every default
		@(posedge ref_clk);
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		// Idle level is high: reset polarity is negative and run resets to one
		`SFPC_CHECK(frame_pulse_out_a, 1'b1)
		rd(`SFPC_OFF_RATE, 8'h05);
		rd(`SFPC_OFF_SHAPE, 8'h83);
		rd(`SFPC_OFF_PHASE_LOW, 8'h00);
		rd(`SFPC_OFF_PHASE_MID, 8'h00);
		rd(`SFPC_OFF_PHASE_HIGH, 8'h00);
		rd(`SFPC_OFF_CTRL, 8'h01);
		// Every rate code; the faster half is timed pulse to pulse
		for (int k = 0; k < 8; k++) begin
			wr(`SFPC_OFF_RATE, 8'(k));
			rd(`SFPC_OFF_RATE, 8'(k));
			if (k >= 4) begin
				wait_pulses(2);
				s0 = act_start;
				wait_pulses(1);
				`SFPC_CHECK(act_start - s0, rate_mult[k] * 625)
			end
		end
		// Fixed widths with an E1-family synth clock; polarity alternates
		for (int w = 0; w < 5; w++) begin
			pol_sel <= w[0];
			wr(`SFPC_OFF_SHAPE, {w[0], w[2:0], 4'h1});
			wait_pulses(3);
			repeat (20) @(posedge ref_clk);
			#1;
			`SFPC_CHECK(act_width, width_exp[w])
			`SFPC_CHECK(frame_pulse_out_a, w[0])
		end
		// Run bit low holds the output low, even with negative polarity
		pol_sel <= 1'b1;
		wr(`SFPC_OFF_SHAPE, 8'h81);
		wr(`SFPC_OFF_CTRL, 8'h00);
		@(posedge ref_clk);
		any_high = 1'b0;
		repeat (700) begin
			@(posedge ref_clk);
			#1;
			any_high = any_high | frame_pulse_out_a;
		end
		`SFPC_CHECK(any_high, 1'b0)
		wr(`SFPC_OFF_CTRL, 8'h01);
		// Clock style: active for half of the 625-cycle frame
		pol_sel <= 1'b0;
		wr(`SFPC_OFF_SHAPE, 8'h00);
		wait_pulses(3);
		repeat (400) @(posedge ref_clk);
		#1;
		`SFPC_CHECK(act_width, 312)
		// Non-E1 synth clock, so only the synth-cycle width is allowed
		synth_e1 <= 1'b0;
		wr(`SFPC_OFF_SHAPE, 8'h71);
		wait_pulses(3);
		repeat (20) @(posedge ref_clk);
		#1;
		`SFPC_CHECK(act_width, 5)
		// Falling edge sits 2 cycles after a rise, or 3 before it
		s0 = act_start;
		wr(`SFPC_OFF_SHAPE, 8'h73);
		wait_pulses(3);
		sh = (act_start - s0) % 625;
		`SFPC_CHECK(sh == 2 || sh == 622, 1'b1)
		// Offset 0x0800 is 312 cycles; the launch snaps to a rise every 5 cycles
		wr(`SFPC_OFF_SHAPE, 8'h71);
		wait_pulses(3);
		s0 = act_start;
		wr(`SFPC_OFF_PHASE_LOW, 8'h00);
		wr(`SFPC_OFF_PHASE_MID, 8'h08);
		wait_pulses(3);
		sh = (act_start - s0) % 625;
		`SFPC_CHECK(sh == 310 || sh == 315, 1'b1)
		print_verdict();
	end
endmodule
